//--- design/rgb_gain_config_decoder.sv
// single-wire receiver with colour path, chain forwarding and gain mode
// assumes serial_in is asynchronous to clk and clk runs at 250 MHz
//
// Operation
// RULE_01 - host may interleave queries after whole words
// RULE_02 - independent 16-level gain per colour channel; the 4-bit code gives 16 levels
// RULE_03 - reset, 20us pulse, reset enters gain mode
// RULE_04 - gain word nibbles at S19, S11, S3
// RULE_05 - level weights 10,4,2,1 seventeenths; reset 0x0F
// RULE_06 - bit value decided by high pulse width
// RULE_07 - low of 250us restarts reception
// RULE_08 - keep first word, forward the rest
// RULE_09 - three bytes, most significant bit first
// RULE_10 - gain mode also keeps first word only
`timescale 1ns/1ps
`include "gain_regs.svh"

////////////////////////////////////////////////////////////////////////////
// word fifo: flop storage, honest full and empty
module word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW-1:0]    wr_q;           // write index
  logic [AW-1:0]    rd_q;           // read index
  logic [AW:0]      cnt_q;          // fill level
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // wrap an index at depth
  function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] i);
    next_idx = (i == AW'(DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction

  // storage write; data needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= next_idx(wr_q);
      end
      if (pop) begin
        rd_q <= next_idx(rd_q);
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo

////////////////////////////////////////////////////////////////////////////
// top: line decoder, sequence tracker, gain store, colour stream
module rgb_gain_config_decoder
  import gain_pkg::*;
#(
  parameter int LINE_RESET_CYC = `LINE_RESET_CYC,  // low cycles for reset
  parameter int FIFO_DEPTH     = `FIFO_DEPTH
) (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  serial_in,        // line from host or previous device
  output logic       serial_out,       // line to next device
  output colour_word_t colour_word,    // held colour word
  output logic       colour_valid,
  input  wire logic  colour_ready,
  output gain_set_t  gain_code,        // current gain codes
  output level_set_t sink_level,       // current in 1/17 of full scale
  output logic       gain_mode,        // gain-setting mode is active
  output logic       word_overflow     // sticky: a word could not be queued
);
  localparam int CW = 17;              // counter width, holds 62500
  localparam logic [CW-1:0] SPLIT_C = CW'(`BIT_SPLIT_CYC);
  localparam logic [CW-1:0] LONG_C  = CW'(`LONG_PULSE_CYC);
  localparam logic [CW-1:0] RST_C   = CW'(LINE_RESET_CYC);
  localparam logic [CW-1:0] CNT_MAX = '1;

  //////////////////////////////////////////////////////////////////////////
  // input synchroniser and edge detect
  logic sync1_q;                       // first stage, read only by sync2
  logic sync2_q;                       // safe line level
  logic line_q;                        // previous safe level
  logic fall;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      line_q  <= 1'b0;
    end else begin
      sync1_q <= serial_in;
      sync2_q <= sync1_q;
      line_q  <= sync2_q;
    end
  end
  assign fall = line_q & ~sync2_q;

  //////////////////////////////////////////////////////////////////////////
  // pulse width measurement
  logic [CW-1:0] high_q;               // cycles of the current high pulse
  logic [CW-1:0] low_q;                // cycles of the current low level
  logic          ev_bit;               // a data bit ended
  logic          ev_one;               // its value
  logic          ev_long;              // the gain-mode pulse ended
  logic          ev_rst;               // line reset detected, one pulse

  // both counters saturate so a stuck line cannot wrap into a bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_q <= '0;
      low_q  <= '0;
    end else begin
      high_q <= sync2_q ? ((high_q == CNT_MAX) ? high_q : high_q + 1'b1)
                        : '0;
      low_q  <= sync2_q ? '0
                        : ((low_q == CNT_MAX) ? low_q : low_q + 1'b1);
    end
  end

  assign ev_long = fall & (high_q >= LONG_C);
  assign ev_bit  = fall & ~ev_long;
  assign ev_one  = (high_q >= SPLIT_C);              // see RULE_06
  // fires once, on the cycle the low level reaches the reset length
  assign ev_rst  = ~sync2_q & (low_q == RST_C - 1'b1); // see RULE_07

  //////////////////////////////////////////////////////////////////////////
  // word assembly and forwarding
  logic [`WORD_BITS-1:0] shift_q;      // bits collected, msb first
  logic [4:0]            nbits_q;      // bits collected so far
  logic                  pass_q;       // own word taken, forward the rest
  logic                  seen_q;       // data bits since last line reset
  logic                  word_done;
  logic [`WORD_BITS-1:0] word_d;

  // first bit lands at the top, so each byte is msb first
  assign word_d    = {shift_q[`WORD_BITS-2:0], ev_one};  // see RULE_09
  assign word_done = ev_bit & ~pass_q &
                     (nbits_q == 5'(`WORD_BITS - 1));

  // a line reset restarts reception in every mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= '0;
      nbits_q <= '0;
      pass_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else if (ev_rst) begin
      nbits_q <= '0;                                 // see RULE_07
      pass_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else if (ev_bit) begin
      seen_q <= 1'b1;
      if (!pass_q) begin
        shift_q <= word_d;
        nbits_q <= word_done ? '0 : nbits_q + 1'b1;
        pass_q  <= word_done;                        // see RULE_08
      end
    end
  end

  // later bits go out unchanged; a query code after a word passes too
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= pass_q & sync2_q;                // see RULE_08, RULE_01
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequence tracker for gain mode
  line_state_t st_q;

  // reset after data arms, long pulse then reset enters gain mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_NORMAL;
    end else begin
      unique case (st_q)
        ST_NORMAL: begin
          if (ev_rst && seen_q) begin
            st_q <= ST_ARMED;                        // see RULE_03
          end
        end
        ST_ARMED: begin
          if (ev_long) begin
            st_q <= ST_PULSED;                       // see RULE_03
          end else if (ev_bit) begin
            st_q <= ST_NORMAL;                       // plain data resumed
          end
        end
        ST_PULSED: begin
          if (ev_rst) begin
            st_q <= ST_GAIN;                         // see RULE_03
          end else if (ev_bit) begin
            st_q <= ST_NORMAL;
          end
        end
        ST_GAIN: begin
          // mode lasts until the frame with the gain word ends
          if (ev_rst) begin
            st_q <= seen_q ? ST_ARMED : ST_GAIN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_mode <= 1'b0;
    end else begin
      gain_mode <= (st_q == ST_GAIN);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gain store and current levels
  // weighted sum of gain bits, in seventeenths of full scale
  function automatic logic [4:0] level_of(input logic [3:0] g);
    level_of = (g[3] ? `W_BIT3 : 5'h00) + (g[2] ? `W_BIT2 : 5'h00) +
               (g[1] ? `W_BIT1 : 5'h00) + (g[0] ? `W_BIT0 : 5'h00);
  endfunction

  // only the first word in gain mode is taken; the rest pass on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_code <= '{`GAIN_RESET, `GAIN_RESET, `GAIN_RESET}; // see RULE_05
    end else if (word_done && st_q == ST_GAIN) begin   // see RULE_10
      gain_code.red   <= word_d[19:16];                // see RULE_04
      gain_code.green <= word_d[11:8];                 // see RULE_04
      gain_code.blue  <= word_d[3:0];                  // see RULE_04
    end
  end

  // level follows the codes one cycle later, 16 values each
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sink_level <= '{`LEVEL_RESET, `LEVEL_RESET, `LEVEL_RESET};
    end else begin
      sink_level.red   <= level_of(gain_code.red);     // see RULE_05, RULE_02
      sink_level.green <= level_of(gain_code.green);   // see RULE_02
      sink_level.blue  <= level_of(gain_code.blue);    // see RULE_02
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // colour word path: pending word, fifo, output register
  logic                  pend_q;       // word waiting for fifo room
  logic [`WORD_BITS-1:0] pend_word_q;
  logic                  fifo_ready;
  logic                  fifo_valid;
  logic [`WORD_BITS-1:0] fifo_data;
  logic                  take;

  // words arrive at most once per frame, so one pending slot covers a
  // short stall; a word finding it still full is counted as lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q        <= 1'b0;
      pend_word_q   <= '0;
      word_overflow <= 1'b0;
    end else begin
      if (word_done && st_q != ST_GAIN) begin
        if (pend_q && !fifo_ready) begin
          word_overflow <= 1'b1;
        end else begin
          pend_q      <= 1'b1;
          pend_word_q <= word_d;
        end
      end else if (pend_q && fifo_ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  word_fifo #(
    .WIDTH (`WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (pend_q),
    .in_ready  (fifo_ready),
    .in_data   (pend_word_q),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_data)
  );

  // refill the output register when empty or being consumed
  assign take = fifo_valid & (~colour_valid | colour_ready);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      colour_valid <= 1'b0;
      colour_word  <= '0;
    end else if (take) begin
      colour_valid <= 1'b1;
      colour_word  <= fifo_data;
    end else if (colour_ready) begin
      colour_valid <= 1'b0;
    end
  end

endmodule // rgb_gain_config_decoder

//--- design/gain_regs.svh
// timing and reset constants of the single-wire gain/colour receiver
// assumes a 4 ns system clock; every count is derived from ns figures
`ifndef GAIN_REGS_SVH
`define GAIN_REGS_SVH

`define CLK_PERIOD_NS    4
// split between a 0.3 us and a 0.9 us high pulse
`define BIT_SPLIT_NS     600
// high pulse at least this long is the gain-mode pulse, not a bit
`define LONG_PULSE_NS    10000
// low level at least this long is a line reset
`define LINE_RESET_NS    250000
// least times round up to whole cycles
`define BIT_SPLIT_CYC    ((`BIT_SPLIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_PULSE_CYC   ((`LONG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINE_RESET_CYC   ((`LINE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define WORD_BITS        24
`define GAIN_RESET       4'hf
// level of a reset gain code, 10+4+2+1 seventeenths
`define LEVEL_RESET      5'h11
`define FIFO_DEPTH       8
// weights of gain bits 3..0, in seventeenths of full scale
`define W_BIT3           5'h0a
`define W_BIT2           5'h04
`define W_BIT1           5'h02
`define W_BIT0           5'h01

`endif

//--- design/gain_pkg.sv
// types shared by the receiver and its bench
// assumes gain_regs.svh supplies the numeric constants
package gain_pkg;

  // one received colour word, first field sent first
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } colour_word_t;

  // per-channel gain codes
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } gain_set_t;

  // per-channel current level in seventeenths of full scale, 0..17
  typedef struct packed {
    logic [4:0] red;
    logic [4:0] green;
    logic [4:0] blue;
  } level_set_t;

  // line sequence tracker, one-hot
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_ARMED  = 4'b0010,
    ST_PULSED = 4'b0100,
    ST_GAIN   = 4'b1000
  } line_state_t;

endpackage

//--- tb/host_line_model.sv
// host model: drives the single-wire line with bits, resets and pulses
// assumes the bench calls its tasks by hierarchical name
`timescale 1ns/1ps
module host_line_model #(
  parameter int RESET_LOW = 62500  // low cycles of a line reset, 250 us
) (
  input  wire logic clk,
  output logic      line_out     // device serial input
);
  initial line_out = 1'b0;  // line idles low

  ////////////////////////////////////////
  // hold a level whole cycles; moves only at the falling edge
  task automatic hold(input logic lvl, input int n);
    line_out <= lvl;
    repeat (n) @(negedge clk);
  endtask

  // a bit is told by its high width in a 1.2 us slot
  task automatic send_bit(input logic b);
    hold(1'b1, b ? 225 : 75);
    hold(1'b0, b ? 75 : 225);
  endtask

  // whole words only, msb first; no query ever splits a word
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) send_bit(w[i]);
  endtask

  task automatic line_reset();
    hold(1'b0, RESET_LOW);
  endtask

  // reset, 20 us pulse, reset: entry into gain setting
  task automatic gain_entry();
    line_reset();
    hold(1'b1, 5000);
    line_reset();
  endtask
endmodule // host_line_model

//--- tb/rgb_gain_config_decoder_sva.sv
// checker for the gain/colour receiver, sees only top-level ports
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module rgb_gain_config_decoder_sva
  import gain_pkg::*;
#(
  parameter int LINE_RESET_CYC = 62500,
  parameter int FIFO_DEPTH     = 8
) (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         serial_in,
  input wire logic         serial_out,
  input wire colour_word_t colour_word,
  input wire logic         colour_valid,
  input wire logic         colour_ready,
  input wire gain_set_t    gain_code,
  input wire level_set_t   sink_level,
  input wire logic         gain_mode,
  input wire logic         word_overflow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  int   low_q;   // cycles of low line
  int   bits_q;  // pin falls since the last long low
  logic pin_q;   // line one cycle ago

  // weighted level of one code, in seventeenths
  function automatic logic [4:0] lvl(input logic [3:0] c);
    return (c[3] ? 5'h0a : 5'h00) + (c[2] ? 5'h04 : 5'h00)
         + (c[1] ? 5'h02 : 5'h00) + {4'h0, c[0]};
  endfunction

  ////////////////////////////////////////
  // low-run counter; raw pin, so it may lead the device by a few cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_q <= 0;
      pin_q <= 1'b0;
    end else begin
      low_q <= serial_in ? 0 : low_q + 1;
      pin_q <= serial_in;
    end
  end

  // bit count, cleared by a long low
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      bits_q <= 0;
    else if (low_q >= LINE_RESET_CYC)
      bits_q <= 0;
    else if (pin_q && !serial_in)
      bits_q <= bits_q + 1;
  end

  sequence s_held;
    colour_valid && !colour_ready;
  endsequence
  sequence s_released;
    $fell(reset);
  endsequence

  ////////////////////////////////////////
  chk_reset_values: assert property (
    s_released |-> gain_code == 12'hfff && !gain_mode && !word_overflow)
    else $error("codes or flags wrong after reset");
  chk_level_weight: assert property (
    sink_level == {lvl($past(gain_code.red)), lvl($past(gain_code.green)),
                   lvl($past(gain_code.blue))})
    else $error("sink level does not match gain code");
  chk_gain_only_mode: assert property (
    !$stable(gain_code) |-> $past(gain_mode))
    else $error("gain code changed outside gain mode");
  chk_out_rise: assert property (
    $rose(serial_out) |-> $past(serial_in, 3) && !$past(serial_in, 4)
                          && bits_q >= 24)
    else $error("forwarded rise without matching input");
  chk_out_fall: assert property (
    $fell(serial_out) |-> !$past(serial_in, 3))
    else $error("forwarded fall without matching input");
  chk_valid_hold: assert property (
    s_held |=> colour_valid && $stable(colour_word))
    else $error("colour word changed before it was taken");
  chk_ovf_sticky: assert property (
    word_overflow |=> word_overflow)
    else $error("overflow flag cleared");
  chk_ovf_full: assert property (
    $rose(word_overflow) |-> colour_valid)
    else $error("overflow while output empty");
endmodule // rgb_gain_config_decoder_sva

bind rgb_gain_config_decoder rgb_gain_config_decoder_sva #(
  .LINE_RESET_CYC(LINE_RESET_CYC), .FIFO_DEPTH(FIFO_DEPTH)
) rgb_gain_config_decoder_sva_inst (
  .clk(clk), .reset(reset), .serial_in(serial_in),
  .serial_out(serial_out), .colour_word(colour_word),
  .colour_valid(colour_valid), .colour_ready(colour_ready),
  .gain_code(gain_code), .sink_level(sink_level),
  .gain_mode(gain_mode), .word_overflow(word_overflow));

//--- tb/tb.sv
// bench for the gain/colour receiver: colour path, gain mode, fifo
// assumes host model and checker are compiled before it
`timescale 1ns/1ps
module tb
  import gain_pkg::*;
;
  localparam int LRC = 300;  // shortened line reset, above bit lows
  localparam int FD  = 4;    // small fifo keeps the fill run short
  localparam logic [23:0] WA = 24'hc35a81;  // own word
  localparam logic [23:0] WB = 24'h3ca57e;  // forwarded word
  logic clk = 1'b0, reset = 1'b1, line, serial_out, colour_valid;
  logic colour_ready = 1'b0, gain_mode, word_overflow;
  colour_word_t colour_word;
  gain_set_t    gain_code;
  level_set_t   sink_level;
  int n_fail = 0, num_checks = 0, out_high = 0;

  initial forever #2 clk = ~clk;
  // forwarded high time, in cycles
  always @(posedge clk) if (serial_out === 1'b1) out_high++;

  rgb_gain_config_decoder #(.LINE_RESET_CYC(LRC), .FIFO_DEPTH(FD))
    rgb_gain_config_decoder_inst (.clk(clk), .reset(reset),
    .serial_in(line), .serial_out(serial_out), .colour_word(colour_word),
    .colour_valid(colour_valid), .colour_ready(colour_ready),
    .gain_code(gain_code), .sink_level(sink_level),
    .gain_mode(gain_mode), .word_overflow(word_overflow));
  host_line_model #(.RESET_LOW(LRC + 20))
    host_line_model_inst (.clk(clk), .line_out(line));

  ////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for an output word
  task automatic wait_valid();
    for (int i = 0; i < 40 && colour_valid !== 1'b1; i++) @(negedge clk);
    if (colour_valid !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  // expected high cycles of a word on the line
  function automatic int hi(input logic [23:0] w);
    hi = 0;
    for (int i = 0; i < 24; i++) hi += w[i] ? 225 : 75;
  endfunction

  ////////////////////////////////////////
  task automatic test_colour();
    host_line_model_inst.line_reset();
    out_high = 0;
    host_line_model_inst.send_word(WA);
    check(out_high, 0);
    wait_valid();
    check(colour_word, WA);
    out_high = 0;
    host_line_model_inst.send_word(WB);
    check(out_high, hi(WB));
    check(colour_word, WA);
    $display("test_colour done");
  endtask

  task automatic test_gain();
    host_line_model_inst.gain_entry();
    check(gain_mode, 1'b1);
    host_line_model_inst.send_word(24'h050c09);
    check(gain_code, 12'h5c9);
    check(sink_level, {5'd5, 5'd14, 5'd11});
    out_high = 0;
    host_line_model_inst.send_word(24'h0a0103);
    check(out_high, hi(24'h0a0103));
    check(gain_code, 12'h5c9);
    $display("test_gain done");
  endtask

  // fill: output holds WA, fifo FD words, pending one, the next is lost
  task automatic test_fill();
    for (int i = 0; i < FD + 2; i++) begin
      host_line_model_inst.line_reset();
      if (i == 0) check(gain_mode, 1'b0);
      host_line_model_inst.send_word({8'h30, 8'(i), 8'hc5});
      check(word_overflow, i == FD + 1);
    end
    for (int j = 0; j < FD + 2; j++) begin
      wait_valid();
      if (j == 0) check(colour_word, WA);
      else check(colour_word, {8'h30, 8'(j - 1), 8'hc5});
      colour_ready = 1'b1;
      @(negedge clk);
      colour_ready = 1'b0;
    end
    repeat (10) @(negedge clk);
    check(colour_valid, 1'b0);
    $display("test_fill done");
  endtask

  initial begin
    repeat (8) @(negedge clk);
    check(gain_code, 12'hfff);
    check(sink_level, {5'd17, 5'd17, 5'd17});
    reset = 1'b0;
    test_colour();
    test_gain();
    test_fill();
    end_sim();
  end
endmodule // tb
